// >>> rtl/mbsf_framer.v
// Serial-line slave framer: receive, gap timing, check, reply forming.
// Assumes rx_i and the switch banks are asynchronous pins; rsp_* from clk_i logic.
`timescale 1ns/1ns
`include "mbsf_map.vh"

module mbsf_fifo #(
  parameter W = 9,
  parameter D = `MBSF_FIFO_DEPTH
) (
  input wire clk_i,
  input wire rst_i,
  input wire flush_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output reg in_ready_o,
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i
);
  localparam AW = $clog2(D);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & out_valid_o;
  reg [AW:0] cnt_d;
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rp_q];
  always @* begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (flush_i) cnt_d = {(AW+1){1'b0}};
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
    end else begin
      if (push) mem_q[wp_q] <= in_data_i;
      if (flush_i) begin
        wp_q <= {AW{1'b0}};
        rp_q <= {AW{1'b0}};
      end else begin
        if (push) wp_q <= (wp_q == D - 1) ? {AW{1'b0}} : wp_q + 1'b1;
        if (pop) rp_q <= (rp_q == D - 1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != D);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mbsf_framer #(
  parameter [15:0] DIV0 = `MBSF_DIV0,
  parameter [15:0] DIV1 = `MBSF_DIV1,
  parameter [15:0] DIV2 = `MBSF_DIV2,
  parameter [15:0] DIV3 = `MBSF_DIV3
) (
  input wire clk_i,
  input wire rst_i,
  input wire rx_i,
  input wire [7:0] node_address_switch_bank_i,
  input wire [3:0] serial_config_switch_bank_i,
  output reg tx_o,
  output reg tx_oe_o,
  output reg req_stb_o,
  output reg [7:0] req_byte_o,
  output reg req_done_o,
  output reg req_ok_o,
  output reg req_bcast_o,
  output reg [7:0] req_func_o,
  input wire rsp_valid_i,
  input wire [7:0] rsp_data_i,
  input wire rsp_last_i,
  output wire rsp_ready_o,
  input wire rsp_go_i,
  input wire rsp_empty_i,
  input wire rsp_exc_i,
  input wire [7:0] rsp_code_i
);
  // Gap limits in half-bit units of an eleven-bit character
  localparam integer T15_I = `MBSF_T15_X10 * 11 * 2 / 10;
  localparam integer T35_I = `MBSF_T35_X10 * 11 * 2 / 10;
  localparam [7:0] T15_HB = T15_I[7:0];
  localparam [7:0] T35_HB = T35_I[7:0];
  localparam [3:0] S_IDLE = 4'h0, S_COLON = 4'h1, S_ADDR = 4'h2, S_FUNC = 4'h3;
  localparam [3:0] S_DATA = 4'h4, S_CK0 = 4'h5, S_CK1 = 4'h6, S_CR = 4'h7;
  localparam [3:0] S_LF = 4'h8;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] r;
    begin
      r = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
        r = r[0] ? ((r >> 1) ^ `MBSF_CRC_POLY) : (r >> 1);
      crc_byte = r;
    end
  endfunction

  function is_hex;
    input [7:0] c;
    begin
      is_hex = (c >= `MBSF_CH_0 && c <= `MBSF_CH_9) ||
               (c >= `MBSF_CH_A && c <= `MBSF_CH_F);
    end
  endfunction

  function [3:0] unhex;
    input [7:0] c;
    begin
      unhex = (c <= `MBSF_CH_9) ? c[3:0] : c[3:0] + 4'h9;
    end
  endfunction

  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'hA) ? (`MBSF_CH_0 | {4'h0, n}) : (`MBSF_CH_A + {4'h0, n} - 8'h0A);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and configuration
  reg rx_s1_q, rx_s2_q;
  reg [7:0] adr_s1_q, adr_s2_q;
  reg [3:0] cfg_s1_q, cfg_s2_q, cfg_prev_q;
  reg [7:0] adr_prev_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      adr_s1_q <= 8'h00;
      adr_s2_q <= 8'h00;
      cfg_s1_q <= 4'h0;
      cfg_s2_q <= 4'h0;
      cfg_prev_q <= 4'h0;
      adr_prev_q <= 8'h00;
    end else begin
      rx_s1_q <= rx_i;
      rx_s2_q <= rx_s1_q;
      adr_s1_q <= node_address_switch_bank_i;
      adr_s2_q <= adr_s1_q;
      cfg_s1_q <= serial_config_switch_bank_i;
      cfg_s2_q <= cfg_s1_q;
      cfg_prev_q <= cfg_s2_q;
      adr_prev_q <= adr_s2_q;
    end
  end
  wire nopar = cfg_s2_q[`MBSF_CFG_NOPAR];
  wire ascii = cfg_s2_q[`MBSF_CFG_ASCII];
  // Switch change aborts any unit being framed; a character or reply already in progress runs on
  wire cfg_chg = (cfg_prev_q != cfg_s2_q) || (adr_prev_q != adr_s2_q);
  wire node_en = (adr_s2_q != `MBSF_ADDR_BCAST) && (adr_s2_q < `MBSF_ADDR_RSV);
  wire [3:0] nbits = ascii ? `MBSF_ASC_BITS : `MBSF_RTU_BITS;
  reg [15:0] div;
  always @* begin
    case (cfg_s2_q[3:2])
      2'h0: div = DIV0;
      2'h1: div = DIV1;
      2'h2: div = DIV2;
      default: div = DIV3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Character receiver and gap timer
  reg rx_busy_q, rx_stb_q;
  reg [15:0] rx_div_q, hb_div_q;
  reg [3:0] rx_bit_q;
  reg [9:0] rx_sh_q;
  reg [7:0] gap_q;
  wire rx_start = !rx_busy_q && !rx_s2_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_busy_q <= 1'b0;
      rx_stb_q <= 1'b0;
      rx_div_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 10'h000;
      hb_div_q <= 16'h0000;
      gap_q <= 8'h00;
    end else begin
      rx_stb_q <= 1'b0;
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_div_q <= {1'b0, div[15:1]};
        rx_bit_q <= 4'h0;
      end else if (rx_busy_q) begin
        if (rx_div_q == 16'h0000) begin
          rx_div_q <= div - 16'h0001;
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0) begin
            if (rx_s2_q) rx_busy_q <= 1'b0;
          end else begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[9:1]};
            if (rx_bit_q == nbits - 4'h1) begin
              rx_busy_q <= 1'b0;
              rx_stb_q <= 1'b1;
            end
          end
        end else begin
          rx_div_q <= rx_div_q - 16'h0001;
        end
      end
      // A switch change restarts the idle count, as reset does
      if (rx_busy_q || cfg_chg) begin
        hb_div_q <= 16'h0000;
        gap_q <= 8'h00;
      end else if (hb_div_q >= {1'b0, div[15:1]} - 16'h0001) begin
        hb_div_q <= 16'h0000;
        if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
      end else begin
        hb_div_q <= hb_div_q + 16'h0001;
      end
    end
  end
  wire [7:0] rx_data = ascii ? {1'b0, rx_sh_q[7:1]} : rx_sh_q[7:0];
  wire ch_ok = rx_sh_q[9] && (nopar ? rx_sh_q[8] : (rx_sh_q[8] == ^rx_data));
  wire idle_ev = !rx_busy_q && (gap_q == T35_HB - 8'h01) && (hb_div_q == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////////
  // Unit framing
  reg fr_act_q, fr_bad_q, fr_wait_q, fr_cr_q, nib_hi_q, allow_q;
  reg [3:0] hi_q;
  reg [7:0] idx_q, addr_q, lrc_q;
  reg [15:0] crc_q;
  wire hexch = is_hex(rx_data);
  wire bev = rx_stb_q && ch_ok && !fr_bad_q && (ascii ?
             (fr_act_q && hexch && !fr_cr_q && nib_hi_q) : !fr_wait_q);
  wire [7:0] bval = ascii ? {hi_q, unhex(rx_data)} : rx_data;
  wire chk_ok = ascii ? (lrc_q == 8'h00) : (crc_q == 16'h0000);
  wire len_ok = ascii ? (idx_q >= `MBSF_ASC_MIN && !nib_hi_q) : (idx_q >= `MBSF_RTU_MIN);
  wire adr_ok = (addr_q == adr_s2_q) || (addr_q == `MBSF_ADDR_BCAST);
  wire unit_ok = !fr_bad_q && chk_ok && len_ok && node_en && adr_ok;
  wire end_ev = ascii ? (rx_stb_q && fr_act_q && fr_cr_q && rx_data == `MBSF_CH_LF)
                      : (idle_ev && fr_act_q);
  wire restart = ascii && rx_stb_q && rx_data == `MBSF_CH_COLON;
  wire tx_go;
  always @(posedge clk_i) begin
    if (rst_i || cfg_chg) begin
      fr_act_q <= 1'b0;
      fr_bad_q <= 1'b0;
      fr_wait_q <= 1'b1;
      fr_cr_q <= 1'b0;
      nib_hi_q <= 1'b0;
      hi_q <= 4'h0;
      idx_q <= 8'h00;
      addr_q <= 8'h00;
      lrc_q <= 8'h00;
      crc_q <= `MBSF_CRC_INIT;
      allow_q <= 1'b0;
      req_stb_o <= 1'b0;
      req_byte_o <= 8'h00;
      req_done_o <= 1'b0;
      req_ok_o <= 1'b0;
      req_bcast_o <= 1'b0;
      req_func_o <= 8'h00;
    end else begin
      req_stb_o <= 1'b0;
      req_done_o <= 1'b0;
      if (tx_go) allow_q <= 1'b0;
      if (end_ev || restart || (!ascii && idle_ev)) begin
        if (end_ev) begin
          req_done_o <= 1'b1;
          req_ok_o <= unit_ok && (ch_ok || !ascii);
          req_bcast_o <= (addr_q == `MBSF_ADDR_BCAST);
          allow_q <= unit_ok && (ch_ok || !ascii) && (addr_q != `MBSF_ADDR_BCAST);
        end
        fr_act_q <= restart;
        fr_bad_q <= 1'b0;
        fr_wait_q <= 1'b0;
        fr_cr_q <= 1'b0;
        nib_hi_q <= 1'b0;
        idx_q <= 8'h00;
        lrc_q <= 8'h00;
        crc_q <= `MBSF_CRC_INIT;
      end else begin
        if (!ascii && rx_start && fr_act_q && gap_q > T15_HB)
          fr_bad_q <= 1'b1;
        if (rx_stb_q && !ch_ok && (fr_act_q || !ascii))
          fr_bad_q <= 1'b1;
        if (ascii && rx_stb_q && fr_act_q && ch_ok) begin
          if (rx_data == `MBSF_CH_CR && !fr_cr_q)
            fr_cr_q <= 1'b1;
          else if (!hexch || fr_cr_q)
            fr_bad_q <= 1'b1;
          else if (!nib_hi_q) begin
            hi_q <= unhex(rx_data);
            nib_hi_q <= 1'b1;
          end
        end
        if (bev) begin
          fr_act_q <= 1'b1;
          nib_hi_q <= 1'b0;
          if (idx_q != 8'hFF) idx_q <= idx_q + 8'h01;
          crc_q <= crc_byte(crc_q, bval);
          lrc_q <= lrc_q + bval;
          if (idx_q == 8'h00) addr_q <= bval;
          if (idx_q == 8'h01) begin
            req_func_o <= bval;
            if (bval > `MBSF_FUNC_MAX) fr_bad_q <= 1'b1;
          end
          if (idx_q != 8'h00) begin
            req_stb_o <= 1'b1;
            req_byte_o <= bval;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply path
  reg [3:0] ts_q;
  reg exc_q, nod_q, nib_q, sd_busy_q;
  reg [7:0] code_q, lrc_t_q;
  reg [15:0] crc_t_q, sd_div_q;
  reg [9:0] sd_sh_q;
  reg [3:0] sd_cnt_q;
  wire f_valid;
  wire [8:0] f_data;
  reg [7:0] cur;
  reg raw, have;
  assign tx_go = rsp_go_i && ts_q == S_IDLE && allow_q;
  always @* begin
    raw = 1'b0;
    have = 1'b1;
    cur = 8'h00;
    case (ts_q)
      S_COLON: begin raw = 1'b1; cur = `MBSF_CH_COLON; end
      S_ADDR: cur = adr_s2_q;
      S_FUNC: cur = req_func_o | (exc_q ? `MBSF_EXC_FLAG : 8'h00);
      S_DATA: begin
        cur = exc_q ? code_q : f_data[7:0];
        have = exc_q || f_valid;
      end
      S_CK0: cur = ascii ? (8'h00 - lrc_t_q) : crc_t_q[7:0];
      S_CK1: cur = crc_t_q[15:8];
      S_CR: begin raw = 1'b1; cur = `MBSF_CH_CR; end
      S_LF: begin raw = 1'b1; cur = `MBSF_CH_LF; end
      default: have = 1'b0;
    endcase
  end
  wire issue = !sd_busy_q && have;
  wire adv = issue && (raw || !ascii || nib_q);
  wire pop = adv && ts_q == S_DATA && !exc_q;
  wire [7:0] ch = (raw || !ascii) ? cur : hexc(nib_q ? cur[3:0] : cur[7:4]);
  wire [7:0] chd = ascii ? {1'b0, ch[6:0]} : ch;
  wire par = nopar ? 1'b1 : ^chd;
  mbsf_fifo #(.W(9), .D(`MBSF_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(rsp_go_i && !tx_go && ts_q == S_IDLE),
    .in_valid_i(rsp_valid_i),
    .in_data_i({rsp_last_i, rsp_data_i}),
    .in_ready_o(rsp_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );
  always @(posedge clk_i) begin
    if (rst_i) begin
      ts_q <= S_IDLE;
      exc_q <= 1'b0;
      nod_q <= 1'b0;
      nib_q <= 1'b0;
      code_q <= 8'h00;
      lrc_t_q <= 8'h00;
      crc_t_q <= `MBSF_CRC_INIT;
      sd_busy_q <= 1'b0;
      sd_div_q <= 16'h0000;
      sd_sh_q <= 10'h3FF;
      sd_cnt_q <= 4'h0;
      tx_o <= 1'b1;
      tx_oe_o <= 1'b0;
    end else begin
      tx_oe_o <= (ts_q != S_IDLE) || sd_busy_q;
      if (tx_go) begin
        ts_q <= ascii ? S_COLON : S_ADDR;
        exc_q <= rsp_exc_i;
        nod_q <= rsp_empty_i;
        code_q <= (rsp_code_i == `MBSF_EXC_FUNC || rsp_code_i == `MBSF_EXC_DATA ||
                   rsp_code_i == `MBSF_EXC_GW) ? rsp_code_i : `MBSF_EXC_FUNC;
        lrc_t_q <= 8'h00;
        crc_t_q <= `MBSF_CRC_INIT;
        nib_q <= 1'b0;
      end else if (issue) begin
        nib_q <= ascii && !raw && !nib_q;
        if (adv && !raw && ts_q != S_CK0 && ts_q != S_CK1) begin
          crc_t_q <= crc_byte(crc_t_q, cur);
          lrc_t_q <= lrc_t_q + cur;
        end
        if (adv) begin
          case (ts_q)
            S_COLON: ts_q <= S_ADDR;
            S_ADDR: ts_q <= S_FUNC;
            S_FUNC: ts_q <= (nod_q && !exc_q) ? S_CK0 : S_DATA;
            S_DATA: ts_q <= (exc_q || f_data[8]) ? S_CK0 : S_DATA;
            S_CK0: ts_q <= ascii ? S_CR : S_CK1;
            S_CR: ts_q <= S_LF;
            default: ts_q <= S_IDLE;
          endcase
        end
      end
      if (issue) begin
        sd_busy_q <= 1'b1;
        sd_div_q <= div - 16'h0001;
        tx_o <= 1'b0;
        sd_sh_q <= ascii ? {2'b11, par, chd[6:0]} : {1'b1, par, chd};
        sd_cnt_q <= nbits - 4'h1;
      end else if (sd_busy_q) begin
        if (sd_div_q == 16'h0000) begin
          sd_div_q <= div - 16'h0001;
          if (sd_cnt_q == 4'h0) begin
            sd_busy_q <= 1'b0;
            tx_o <= 1'b1;
          end else begin
            tx_o <= sd_sh_q[0];
            sd_sh_q <= {1'b1, sd_sh_q[9:1]};
            sd_cnt_q <= sd_cnt_q - 4'h1;
          end
        end else begin
          sd_div_q <= sd_div_q - 16'h0001;
        end
      end
    end
  end
endmodule

// >>> rtl/mbsf_map.vh
// Constants for the serial-line slave framer: timing, characters, codes.
// Assumes inclusion by bare name from the framer source.
`ifndef MBSF_MAP_VH
`define MBSF_MAP_VH
`define MBSF_CLK_HZ 125000000
// Bit dividers for 9600, 19200, 38400 and 115200 baud at the clock above
`define MBSF_DIV0 16'h32DC
`define MBSF_DIV1 16'h196E
`define MBSF_DIV2 16'h0CB7
`define MBSF_DIV3 16'h043D
`define MBSF_RTU_BITS 4'hB
`define MBSF_ASC_BITS 4'hA
`define MBSF_T15_X10 15
`define MBSF_T35_X10 35
`define MBSF_FUNC_MAX 8'h7F
`define MBSF_EXC_FLAG 8'h80
`define MBSF_EXC_FUNC 8'h01
`define MBSF_EXC_DATA 8'h03
`define MBSF_EXC_GW 8'h0B
`define MBSF_ADDR_BCAST 8'h00
`define MBSF_ADDR_RSV 8'hF8
`define MBSF_CH_COLON 8'h3A
`define MBSF_CH_CR 8'h0D
`define MBSF_CH_LF 8'h0A
`define MBSF_CH_0 8'h30
`define MBSF_CH_9 8'h39
`define MBSF_CH_A 8'h41
`define MBSF_CH_F 8'h46
`define MBSF_CRC_INIT 16'hFFFF
`define MBSF_CRC_POLY 16'hA001
`define MBSF_CFG_NOPAR 0
`define MBSF_CFG_ASCII 1
`define MBSF_RTU_MIN 8'h04
`define MBSF_ASC_MIN 8'h03
`define MBSF_FIFO_DEPTH 8
`endif

// >>> tb/mbsf_framer_asserts.sv
// Port-level checker for the serial-line slave framer.
// Assumes a bind onto mbsf_framer; one clock, rst_i synchronous and active high.
`timescale 1ns/1ns
module mbsf_framer_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire tx_o,
  input wire tx_oe_o,
  input wire req_stb_o,
  input wire req_done_o,
  input wire req_ok_o,
  input wire req_bcast_o,
  input wire [7:0] req_func_o,
  input wire rsp_go_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  a_go_starts: assert property (rsp_go_i && !tx_oe_o && req_ok_o && !req_bcast_o
    |=> !tx_oe_o ##1 (tx_oe_o && !tx_o)) else $error("reply did not start after go");
  a_bcast_quiet: assert property (rsp_go_i && req_bcast_o && !tx_oe_o
    |=> !tx_oe_o [*8]) else $error("reply driven for broadcast unit");
  a_bad_quiet: assert property (rsp_go_i && !req_ok_o && !tx_oe_o
    |=> !tx_oe_o [*8]) else $error("reply driven for rejected unit");
  a_idle_high: assert property (!tx_oe_o |-> tx_o)
    else $error("transmit line not high while released");
  a_oe_hold: assert property ($rose(tx_oe_o) |=> tx_oe_o [*8])
    else $error("driver enable dropped inside first character");
  a_done_pulse: assert property (req_done_o |=> !req_done_o)
    else $error("unit end flag longer than one cycle");
  a_stb_space: assert property (req_stb_o |=> !req_stb_o [*8])
    else $error("byte strobes closer than one character");
  a_func_range: assert property (req_done_o && req_ok_o |-> !req_func_o[7])
    else $error("accepted unit with function above 7F");
endmodule

// >>> tb/mbsf_master.sv
// Model of the single bus master: sends characters, decodes the slave reply.
// Assumes BIT clocks per bit; called from the bench just after a rising edge.
`timescale 1ns/1ns
module mbsf_master #(
  parameter BIT = 16
) (
  input wire clk_i,
  output reg line_o,
  input wire line_i,
  input wire oe_i
);
  logic [7:0] got[$];
  logic [7:0] v;
  integer i;

  initial line_o = 1'b1;

  task bitt(input logic x);
    begin
      line_o = x;
      repeat (BIT) @(posedge clk_i);
      #1;
    end
  endtask

  // Start, data LSB first, parity slot, stop; next character follows at once
  task send(input logic [7:0] b, input integer n, input logic p);
    integer k;
    begin
      bitt(1'b0);
      for (k = 0; k < n; k++) bitt(b[k]);
      bitt(p);
      bitt(1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reply decoder, binary framing
  initial forever begin
    @(negedge line_i);
    // Qualify the start bit at its middle, with the driver enabled
    repeat (BIT / 2) @(posedge clk_i);
    if (oe_i === 1'b1 && line_i === 1'b0) begin
      v = 8'h00;
      for (i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        v[i] = line_i;
      end
      repeat (BIT * 2) @(posedge clk_i);
      got.push_back(v);
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the serial-line slave framer.
// Assumes all baud dividers set to BIT so a character is 11 or 10 times BIT clocks.
`timescale 1ns/1ns
bind mbsf_framer mbsf_framer_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .tx_o(tx_o),
  .tx_oe_o(tx_oe_o), .req_stb_o(req_stb_o), .req_done_o(req_done_o), .req_ok_o(req_ok_o),
  .req_bcast_o(req_bcast_o), .req_func_o(req_func_o), .rsp_go_i(rsp_go_i));

module tb_top;
  localparam int BIT = 16;
  logic clk_i = 0, rst_i = 1, rx_i, tx_o, tx_oe_o, req_stb_o, req_done_o, req_ok_o;
  logic req_bcast_o, rsp_valid_i = 0, rsp_last_i = 0, rsp_ready_o, rsp_go_i = 0;
  logic rsp_empty_i = 0, rsp_exc_i = 0, par_en = 0;
  logic [7:0] sw = 8'h11, req_byte_o, req_func_o, rsp_data_i = 0, rsp_code_i = 0;
  logic [3:0] cfg = 4'h1;
  logic [7:0] f[$], rq[$];
  logic [9:0] dq[$];
  integer err_count = 0;
  integer samples_checked = 0;

  always #4 clk_i = ~clk_i;

  mbsf_framer #(.DIV0(16'h0010), .DIV1(16'h0010), .DIV2(16'h0010), .DIV3(16'h0010)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i), .node_address_switch_bank_i(sw),
    .serial_config_switch_bank_i(cfg), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .req_stb_o(req_stb_o), .req_byte_o(req_byte_o), .req_done_o(req_done_o),
    .req_ok_o(req_ok_o), .req_bcast_o(req_bcast_o), .req_func_o(req_func_o),
    .rsp_valid_i(rsp_valid_i), .rsp_data_i(rsp_data_i), .rsp_last_i(rsp_last_i),
    .rsp_ready_o(rsp_ready_o), .rsp_go_i(rsp_go_i), .rsp_empty_i(rsp_empty_i),
    .rsp_exc_i(rsp_exc_i), .rsp_code_i(rsp_code_i));

  mbsf_master #(.BIT(BIT)) master_u (.clk_i(clk_i), .line_o(rx_i), .line_i(tx_o),
    .oe_i(tx_oe_o));

  always @(posedge clk_i) begin
    if (req_stb_o === 1'b1) rq.push_back(req_byte_o);
    if (req_done_o === 1'b1) dq.push_back({req_ok_o, req_bcast_o, req_func_o});
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] e, input logic [15:0] s);
    begin
      samples_checked++;
      if (s !== e) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", what, e, s);
      end
    end
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int j = 0; j < q.size(); j++) begin
      c = c ^ q[j];
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  function automatic logic [7:0] hc(input logic [3:0] n);
    return (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction

  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask

  task setcfg(input logic [7:0] s, input logic [3:0] c);
    begin
      sw = s;
      cfg = c;
      cyc(800);
    end
  endtask

  // Mode 0 good, 1 wrong check, 2 late third byte, 3 wrong parity on third byte
  task send_rtu(input integer mode);
    logic [15:0] c;
    begin
      c = crc16(f) ^ ((mode == 1) ? 16'h0001 : 16'h0000);
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      rq = {};
      for (int j = 0; j < f.size(); j++) begin
        if (mode == 2 && j == 2) cyc(BIT * 11 * 5 / 2);
        master_u.send(f[j], 8, par_en ? (^f[j]) ^ (mode == 3 && j == 2) : 1'b1);
      end
    end
  endtask

  task send_asc(input logic bad);
    logic [7:0] s;
    begin
      s = 8'h00;
      for (int j = 0; j < f.size(); j++) s = s + f[j];
      f.push_back(-s);
      master_u.send(8'h3A, 7, 1'b1);
      for (int j = 0; j < f.size(); j++) begin
        master_u.send(hc(f[j][7:4]), 7, 1'b1);
        master_u.send(hc(f[j][3:0]), 7, 1'b1);
      end
      if (bad) master_u.send(8'h47, 7, 1'b1);
      master_u.send(8'h0D, 7, 1'b1);
      master_u.send(8'h0A, 7, 1'b1);
    end
  endtask

  task wait_done(input logic ok, input logic bc, input logic [7:0] fn);
    logic [9:0] d;
    begin
      for (int n = 0; n < 3000 && dq.size() == 0; n++) cyc(1);
      chk("req_done", 1, dq.size() != 0);
      if (dq.size() != 0) begin
        d = dq.pop_front();
        chk("req_ok", ok, d[9]);
        chk("req_bcast", bc, d[8]);
        if (ok) chk("req_func", fn, d[7:0]);
      end
    end
  endtask

  task push(input logic [7:0] d, input logic last);
    begin
      rsp_valid_i = 1;
      rsp_data_i = d;
      rsp_last_i = last;
      for (int n = 0; n < 4000 && rsp_ready_o !== 1'b1; n++) cyc(1);
      cyc(1);
      rsp_valid_i = 0;
      cyc(1);
    end
  endtask

  task go;
    begin
      rsp_go_i = 1;
      cyc(1);
      rsp_go_i = 0;
    end
  endtask

  task quiet;
    begin
      go();
      cyc(40);
      chk("tx_oe", 0, tx_oe_o);
    end
  endtask

  // Normal or exception reply, checked byte by byte at the master
  task reply(input logic [7:0] fn, input integer nd, input logic exc, input logic [7:0] code);
    logic [7:0] r[$];
    logic [15:0] c;
    begin
      r = {8'h11, fn | (exc ? 8'h80 : 8'h00)};
      for (int j = 0; j < nd; j++) r.push_back(8'hA0 + j);
      if (exc) r.push_back((code inside {8'h01, 8'h03, 8'h0B}) ? code : 8'h01);
      c = crc16(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
      master_u.got = {};
      rsp_exc_i = exc;
      rsp_empty_i = (nd == 0);
      rsp_code_i = code;
      for (int j = 0; j < nd && j < 8; j++) push(8'hA0 + j, j == nd - 1);
      if (nd > 8) chk("rsp_ready", 0, rsp_ready_o);
      go();
      for (int j = 8; j < nd; j++) push(8'hA0 + j, j == nd - 1);
      for (int n = 0; n < 100 && tx_oe_o !== 1'b1; n++) cyc(1);
      for (int n = 0; n < 6000 && tx_oe_o !== 1'b0; n++) cyc(1);
      cyc(2 * BIT);
      chk("reply_len", r.size(), master_u.got.size());
      for (int j = 0; j < r.size(); j++) chk("reply_byte", r[j], master_u.got[j]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_normal;
    begin
      f = {8'h11, 8'h03, 8'h00, 8'h05, 8'h00, 8'h02};
      send_rtu(0);
      wait_done(1, 0, 8'h03);
      chk("req_count", f.size() - 1, rq.size());
      for (int j = 1; j < f.size(); j++) chk("req_byte", f[j], rq[j - 1]);
      reply(8'h03, 10, 0, 8'h00);
    end
  endtask

  task t_exc;
    logic [7:0] cs[4];
    begin
      cs = '{8'h01, 8'h03, 8'h0B, 8'h07};
      for (int k = 0; k < 4; k++) begin
        f = {8'h11, 8'h2B, 8'h0E};
        send_rtu(0);
        wait_done(1, 0, 8'h2B);
        reply(8'h2B, 0, 1, cs[k]);
      end
    end
  endtask

  task t_bad;
    begin
      f = {8'h11, 8'h06, 8'h00, 8'h01};
      send_rtu(1);
      wait_done(0, 0, 8'h00);
      quiet();
      f = {8'h00, 8'h06, 8'h00, 8'h01};
      send_rtu(0);
      wait_done(1, 1, 8'h06);
      quiet();
      f = {8'h11, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07};
      send_rtu(2);
      wait_done(0, 0, 8'h00);
      f = {8'h11, 8'h86, 8'h00};
      send_rtu(0);
      wait_done(0, 0, 8'h00);
    end
  endtask

  task t_switches;
    begin
      setcfg(8'hF8, 4'h1);
      f = {8'hF8, 8'h06, 8'h00};
      send_rtu(0);
      wait_done(0, 0, 8'h00);
      par_en = 1;
      setcfg(8'h11, 4'h0);
      f = {8'h11, 8'h06, 8'h00};
      send_rtu(0);
      wait_done(1, 0, 8'h06);
      f = {8'h11, 8'h06, 8'h00};
      send_rtu(3);
      wait_done(0, 0, 8'h00);
    end
  endtask

  task t_ascii;
    begin
      par_en = 0;
      setcfg(8'h11, 4'h3);
      f = {8'h11, 8'h06, 8'h00, 8'h01, 8'h00, 8'h2A};
      send_asc(0);
      f = {8'h11, 8'h06, 8'h00};
      send_asc(1);
      wait_done(1, 0, 8'h06);
      wait_done(0, 0, 8'h00);
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  initial begin
    cyc(8);
    rst_i = 0;
    cyc(800);
    t_normal();
    t_exc();
    t_bad();
    t_switches();
    t_ascii();
    results();
  end

  initial begin
    cyc(90000);
    err_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end
endmodule
